// [core/opd_config_decode.sv]
// How it works
// - Upper switch bit kills switching and monitor
// - Bus clock is system clock over 1,2,4,8
// - Clock output only when enabled, primary off/external
// - Primary mode: off, fast crystal, crystal, external
// - Switchover bit starts on internal oscillator first for primary, primary PLL or secondary source
// - Secondary oscillator follows its enable bit
// - Three-bit field picks start-up clock source
// - PLL output divisor 1 to 256
// - USB PLL disable bit disables and bypasses it
// - USB PLL input divider 1 to 12
// - System PLL multiplier 15 to 24
//
// Implementation choices: the register offsets and register access over APB.
module opd_config_decode (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire opd_pkg::opd_apb_req_s apb_req,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [31:0]          clock_config_word_one,
	input  wire logic [31:0]          pll_config_word_two,
	input  wire logic                 osc_ready,
	input  wire logic [15:0]          pll_ref_khz,
	output opd_pkg::opd_setup_s       clock_setup,
	output opd_pkg::opd_src_e         active_source,
	output logic                      periph_bus_enable,
	output logic [1:0]                periph_bus_divisor,
	output logic                      clock_output,
	output logic                      clock_output_oe,
	output logic [23:0]               pll_out_khz
);

	typedef struct packed {
		logic               loaded;
		logic [31:0]        word_one;
		logic [31:0]        word_two;
		opd_pkg::opd_setup_s setup;
		opd_pkg::opd_start_e start;
		opd_pkg::opd_src_e  source;
		logic [1:0]         ctl_div;
		logic               ctl_ovr;
		logic [2:0]         pb_count;
		logic               pb_en;
		logic               clk_out;
		logic [31:0]        rdata;
		logic [23:0]        pll_khz;
	} opd_state_s;

	opd_state_s state_reg;
	opd_state_s state_next;
	opd_pkg::opd_setup_s dec;
	logic [1:0]  pb_div;
	logic [2:0]  pb_mask;
	logic        rsvd_ok;
	logic        conflict;
	logic        addr_ok;
	logic        setup_phase;
	logic        wr_access;
	logic [20:0] pll_product;

	// Field decode straight off the incoming words
	always_comb begin
		dec = '0;
		// Switching and monitor enables
		dec.switch_enable  = ~clock_config_word_one[opd_pkg::W1_SWMON_HI];
		dec.monitor_enable = ~clock_config_word_one[opd_pkg::W1_SWMON_HI]
			& ~clock_config_word_one[opd_pkg::W1_SWMON_LO];
		dec.prim_osc_mode = opd_pkg::opd_posc_e'(
			clock_config_word_one[opd_pkg::W1_POSC_HI:opd_pkg::W1_POSC_LO]);
		dec.prim_osc_enable = (dec.prim_osc_mode != opd_pkg::POSC_OFF);
		// Pin only carries a clock when no crystal sits on it
		dec.clock_output_enable = ~clock_config_word_one[opd_pkg::W1_CLKOUT]
			& ((dec.prim_osc_mode == opd_pkg::POSC_OFF)
			| (dec.prim_osc_mode == opd_pkg::POSC_EXT_CLOCK));
		dec.two_speed_startup_enable = clock_config_word_one[opd_pkg::W1_TWOSPD];
		dec.secondary_osc_enable = clock_config_word_one[opd_pkg::W1_SOSC];
		dec.oscillator_source_select = opd_pkg::opd_src_e'(
			clock_config_word_one[opd_pkg::W1_SRC_HI:opd_pkg::W1_SRC_LO]);
		// Output divisor is a power of two, kept as a shift too
		case (pll_config_word_two[opd_pkg::W2_ODIV_HI:opd_pkg::W2_ODIV_LO])
			3'b111: dec.pll_output_shift = 4'h8;
			default: dec.pll_output_shift = {1'b0,
				pll_config_word_two[opd_pkg::W2_ODIV_HI:opd_pkg::W2_ODIV_LO]};
		endcase
		dec.pll_output_divisor = 9'(9'h001 << dec.pll_output_shift);
		dec.usb_pll_enable = ~pll_config_word_two[opd_pkg::W2_USBDIS];
		dec.usb_pll_bypass = pll_config_word_two[opd_pkg::W2_USBDIS];
		case (pll_config_word_two[opd_pkg::W2_UDIV_HI:opd_pkg::W2_UDIV_LO])
			3'b000: dec.usb_pll_input_divider = 4'h1;
			3'b001: dec.usb_pll_input_divider = 4'h2;
			3'b010: dec.usb_pll_input_divider = 4'h3;
			3'b011: dec.usb_pll_input_divider = 4'h4;
			3'b100: dec.usb_pll_input_divider = 4'h5;
			3'b101: dec.usb_pll_input_divider = 4'h6;
			3'b110: dec.usb_pll_input_divider = 4'hA;
			default: dec.usb_pll_input_divider = 4'hC;
		endcase
		// Linear run 15..21, then a jump to 24
		case (pll_config_word_two[opd_pkg::W2_MUL_HI:opd_pkg::W2_MUL_LO])
			3'b111: dec.pll_multiplier = 5'h18;
			default: dec.pll_multiplier = 5'(5'h0F
				+ pll_config_word_two[opd_pkg::W2_MUL_HI:opd_pkg::W2_MUL_LO]);
		endcase
	end

	// Health checks on the captured words, reported only
	assign rsvd_ok = ((state_reg.word_one & opd_pkg::W1_RSVD_MASK) == opd_pkg::W1_RSVD_MASK)
		& ((state_reg.word_two & opd_pkg::W2_RSVD_MASK) == opd_pkg::W2_RSVD_MASK);
	assign conflict = (state_reg.setup.prim_osc_mode == opd_pkg::POSC_OFF)
		& (state_reg.setup.oscillator_source_select == opd_pkg::SRC_PRIMARY);

	// Software may override the default bus divisor at run time
	assign pb_div = state_reg.ctl_ovr ? state_reg.ctl_div
		: state_reg.word_one[opd_pkg::W1_PBDIV_HI:opd_pkg::W1_PBDIV_LO];
	assign pb_mask = 3'(({1'b0, 3'b001} << pb_div) - 4'h1);

	// Undivided reference input times multiplier, then the power-of-two divide
	// Both operands widened first so the product is never cut at 16 bits
	assign pll_product = {5'h00, pll_ref_khz}
		* {16'h0000, state_reg.setup.pll_multiplier};

	// Bus decode; zero wait states so pready stays high
	assign setup_phase = apb_req.psel & ~apb_req.penable;
	assign wr_access   = apb_req.psel & apb_req.penable & apb_req.pwrite;
	always_comb begin
		case (apb_req.paddr)
			opd_pkg::OFF_WORD_ONE,
			opd_pkg::OFF_WORD_TWO,
			opd_pkg::OFF_STATUS,
			opd_pkg::OFF_CONTROL,
			opd_pkg::OFF_PLL_FREQ: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// Next-state for the whole block
	always_comb begin
		state_next = state_reg;
		// One-shot capture; nothing reloads until the next reset
		if (!state_reg.loaded) begin
			state_next.loaded   = 1'b1;
			state_next.word_one = clock_config_word_one;
			state_next.word_two = pll_config_word_two;
			state_next.setup    = dec;
			state_next.ctl_div  = clock_config_word_one[opd_pkg::W1_PBDIV_HI:opd_pkg::W1_PBDIV_LO];
		end

		// Start-up sequencing; only sources fed from outside need warm-up
		case (state_reg.start)
			opd_pkg::ST_WAIT_LOAD: begin
				if (state_reg.loaded) begin
					if (state_reg.setup.two_speed_startup_enable
						&& (state_reg.setup.oscillator_source_select == opd_pkg::SRC_PRIMARY
						|| state_reg.setup.oscillator_source_select == opd_pkg::SRC_PRIMARY_PLL
						|| state_reg.setup.oscillator_source_select == opd_pkg::SRC_SECONDARY)) begin
						state_next.start  = opd_pkg::ST_INTERNAL;
						state_next.source = opd_pkg::SRC_FAST_RC;
					end else begin
						state_next.start  = opd_pkg::ST_RUN;
						state_next.source = state_reg.setup.oscillator_source_select;
					end
				end
			end
			opd_pkg::ST_INTERNAL: begin
				if (osc_ready) begin
					state_next.start  = opd_pkg::ST_RUN;
					state_next.source = state_reg.setup.oscillator_source_select;
				end
			end
			opd_pkg::ST_RUN: begin
				state_next.start = opd_pkg::ST_RUN;
			end
			default: begin
				state_next.start = opd_pkg::ST_WAIT_LOAD;
			end
		endcase

		// Free-running bus clock enable, one pulse per divide period
		state_next.pb_count = 3'(state_reg.pb_count + 3'h1);
		state_next.pb_en    = state_reg.loaded
			&& ((state_reg.pb_count & pb_mask) == pb_mask);

		// Output pin clock at half the system rate
		state_next.clk_out = state_reg.setup.clock_output_enable
			& ~state_reg.clk_out;

		state_next.pll_khz = 24'(pll_product >> state_reg.setup.pll_output_shift);

		// Control is the only writable register
		if (wr_access && apb_req.paddr == opd_pkg::OFF_CONTROL) begin
			state_next.ctl_div = apb_req.pwdata[opd_pkg::CTL_DIV_HI:opd_pkg::CTL_DIV_LO];
			state_next.ctl_ovr = apb_req.pwdata[opd_pkg::CTL_OVR];
		end

		// Read data is registered in the setup cycle
		if (setup_phase) begin
			case (apb_req.paddr)
				opd_pkg::OFF_WORD_ONE: state_next.rdata = state_reg.word_one;
				opd_pkg::OFF_WORD_TWO: state_next.rdata = state_reg.word_two;
				opd_pkg::OFF_STATUS:   state_next.rdata = {25'h000_0000, state_reg.source,
					(state_reg.start == opd_pkg::ST_RUN), conflict, rsvd_ok,
					state_reg.loaded};
				opd_pkg::OFF_CONTROL:  state_next.rdata = {29'h0000_0000, state_reg.ctl_ovr,
					state_reg.ctl_div};
				opd_pkg::OFF_PLL_FREQ: state_next.rdata = {8'h00, state_reg.pll_khz};
				default:               state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// Single state register; reset values are constants only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops except the bus divisor mux, handshake combinational
	assign prdata             = state_reg.rdata;
	assign pready             = 1'b1;
	assign pslverr            = apb_req.psel & apb_req.penable & (~addr_ok
		| (apb_req.pwrite & (apb_req.paddr != opd_pkg::OFF_CONTROL)));
	assign clock_setup        = state_reg.setup;
	assign active_source      = state_reg.source;
	assign periph_bus_enable  = state_reg.pb_en;
	assign periph_bus_divisor = pb_div;
	assign clock_output       = state_reg.clk_out;
	assign clock_output_oe    = state_reg.setup.clock_output_enable;
	assign pll_out_khz        = state_reg.pll_khz;

endmodule

// [inc/opd_pkg.sv]
package opd_pkg;

	// Register byte offsets on the APB window
	localparam logic [7:0] OFF_WORD_ONE = 8'h00;
	localparam logic [7:0] OFF_WORD_TWO = 8'h04;
	localparam logic [7:0] OFF_STATUS   = 8'h08;
	localparam logic [7:0] OFF_CONTROL  = 8'h0C;
	localparam logic [7:0] OFF_PLL_FREQ = 8'h10;

	// Field positions in clock_config_word_one
	localparam int W1_SWMON_HI = 15;
	localparam int W1_SWMON_LO = 14;
	localparam int W1_PBDIV_HI = 13;
	localparam int W1_PBDIV_LO = 12;
	localparam int W1_CLKOUT   = 10;
	localparam int W1_POSC_HI  = 9;
	localparam int W1_POSC_LO  = 8;
	localparam int W1_TWOSPD   = 7;
	localparam int W1_SOSC     = 5;
	localparam int W1_SRC_HI   = 2;
	localparam int W1_SRC_LO   = 0;

	// Field positions in pll_config_word_two
	localparam int W2_ODIV_HI = 18;
	localparam int W2_ODIV_LO = 16;
	localparam int W2_USBDIS  = 15;
	localparam int W2_UDIV_HI = 10;
	localparam int W2_UDIV_LO = 8;
	localparam int W2_MUL_HI  = 6;
	localparam int W2_MUL_LO  = 4;

	// Bits that must be programmed as ones
	localparam logic [31:0] W1_RSVD_MASK = 32'h0000_0858;
	localparam logic [31:0] W2_RSVD_MASK = 32'hFFF8_7888;

	// Control register fields
	localparam int CTL_DIV_HI = 1;
	localparam int CTL_DIV_LO = 0;
	localparam int CTL_OVR    = 2;

	typedef enum logic [1:0] {
		POSC_EXT_CLOCK = 2'b00,
		POSC_STD_XTAL  = 2'b01,
		POSC_HS_XTAL   = 2'b10,
		POSC_OFF       = 2'b11
	} opd_posc_e;

	typedef enum logic [2:0] {
		SRC_FAST_RC      = 3'b000,
		SRC_FAST_RC_PLL  = 3'b001,
		SRC_PRIMARY      = 3'b010,
		SRC_PRIMARY_PLL  = 3'b011,
		SRC_SECONDARY    = 3'b100,
		SRC_LOW_POWER_RC = 3'b101,
		SRC_FAST_RC_D16  = 3'b110,
		SRC_FAST_RC_DIVN = 3'b111
	} opd_src_e;

	typedef enum logic [1:0] {
		ST_WAIT_LOAD = 2'b00,
		ST_INTERNAL  = 2'b01,
		ST_RUN       = 2'b10
	} opd_start_e;

	// Decoded clock setup, fixed from load until next reset
	typedef struct packed {
		logic      switch_enable;
		logic      monitor_enable;
		logic      prim_osc_enable;
		opd_posc_e prim_osc_mode;
		logic      clock_output_enable;
		logic      two_speed_startup_enable;
		logic      secondary_osc_enable;
		opd_src_e  oscillator_source_select;
		logic [8:0] pll_output_divisor;
		logic [3:0] pll_output_shift;
		logic      usb_pll_enable;
		logic      usb_pll_bypass;
		logic [3:0] usb_pll_input_divider;
		logic [4:0] pll_multiplier;
	} opd_setup_s;

	// APB request bundle
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} opd_apb_req_s;

endpackage

// [tb/opd_config_decode_chk.sv]
module opd_config_decode_chk (
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic [31:0]         clock_config_word_one,
	input wire logic [31:0]         pll_config_word_two,
	input wire logic [15:0]         pll_ref_khz,
	input wire opd_pkg::opd_setup_s clock_setup,
	input wire opd_pkg::opd_src_e   active_source,
	input wire logic                periph_bus_enable,
	input wire logic [1:0]          periph_bus_divisor,
	input wire logic [23:0]         pll_out_khz,
	input wire logic                clock_output,
	input wire logic                clock_output_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] UDIV [8] = '{1, 2, 3, 4, 5, 6, 10, 12};
	localparam logic [4:0] MUL  [8] = '{15, 16, 17, 18, 19, 20, 21, 24};
	logic [3:0]          up_reg;
	logic [31:0]         w1;
	logic [31:0]         w2;
	opd_pkg::opd_setup_s s;
	assign w1 = clock_config_word_one;
	assign w2 = pll_config_word_two;
	assign s  = clock_setup;
	// Edges since release; decode is valid only after the load edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up_reg <= 4'h0;
		end else if (up_reg != 4'hF) begin
			up_reg <= up_reg + 4'h1;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_sw; up_reg != 0 |-> s.switch_enable == !w1[15]
		&& s.monitor_enable == (w1[15:14] == 2'h0); endproperty
	a_sw: assert property (p_sw) else $error("switch monitor decode");
	// Mask change leaves the free counter alone, so the 8-cycle spacing holds
	property p_pb8; (periph_bus_divisor == 2'h3)[*8] ##0 periph_bus_enable && up_reg == 4'hF
		|-> $past(periph_bus_enable, 8); endproperty
	a_pb8: assert property (p_pb8) else $error("bus pulse spacing");
	// Divide by one means a pulse on every cycle
	property p_pb1; up_reg >= 4'h2 && $past(periph_bus_divisor) == 2'h0
		|-> periph_bus_enable; endproperty
	a_pb1: assert property (p_pb1) else $error("bus pulse every cycle");
	// Pin enable from the word, pin toggles only while enabled
	property p_clock_output; up_reg >= 4'h2 |-> clock_output_oe == (!w1[10] && w1[9] == w1[8])
		&& (clock_output_oe ? clock_output != $past(clock_output) : !clock_output); endproperty
	a_clock_output: assert property (p_clock_output) else $error("clock output pin");
	property p_posc; up_reg != 0 |-> s.prim_osc_mode == w1[9:8]
		&& s.clock_output_enable == (!w1[10] && w1[9] == w1[8]); endproperty
	a_posc: assert property (p_posc) else $error("primary or clock out decode");
	property p_src; up_reg != 0 |-> s.two_speed_startup_enable == w1[7]
		&& s.secondary_osc_enable == w1[5] && s.oscillator_source_select == w1[2:0]; endproperty
	a_src: assert property (p_src) else $error("source decode");
	property p_odiv; up_reg != 0 |-> s.pll_output_divisor
		== (w2[18:16] == 3'h7 ? 9'h100 : 9'h1 << w2[18:16]); endproperty
	a_odiv: assert property (p_odiv) else $error("output divisor");
	property p_usb; up_reg != 0 |-> s.usb_pll_enable == !w2[15] && s.usb_pll_bypass == w2[15]
		&& s.usb_pll_input_divider == UDIV[w2[10:8]]; endproperty
	a_usb: assert property (p_usb) else $error("usb pll decode");
	property p_mul; up_reg != 0 |-> s.pll_multiplier == MUL[w2[6:4]]; endproperty
	a_mul: assert property (p_mul) else $error("multiplier decode");
	property p_hold; up_reg >= 4'h2 |-> $stable(clock_setup); endproperty
	a_hold: assert property (p_hold) else $error("setup changed");
	property p_frq; up_reg == 4'hF |-> pll_out_khz == 24'((32'($past(pll_ref_khz))
		* MUL[w2[6:4]]) >> (w2[18:16] == 3'h7 ? 8 : w2[18:16])); endproperty
	a_frq: assert property (p_frq) else $error("pll frequency");
	property p_st; up_reg >= 4'h2 && !w1[7] |-> active_source == w1[2:0]; endproperty
	a_st: assert property (p_st) else $error("start source");
	c_two: cover property (s.two_speed_startup_enable && active_source == 3'h0);
	c_pb8: cover property ((periph_bus_divisor == 2'h3)[*8] ##0 periph_bus_enable);
	c_usb: cover property (up_reg[1] && s.usb_pll_bypass);
endmodule
bind opd_config_decode opd_config_decode_chk i_chk (.pclk(pclk), .presetn(presetn),
	.clock_config_word_one(clock_config_word_one), .pll_config_word_two(pll_config_word_two),
	.pll_ref_khz(pll_ref_khz), .clock_setup(clock_setup), .active_source(active_source),
	.periph_bus_enable(periph_bus_enable), .periph_bus_divisor(periph_bus_divisor),
	.pll_out_khz(pll_out_khz), .clock_output(clock_output),
	.clock_output_oe(clock_output_oe));

// [tb/opd_config_decode_tb_top.sv]
module opd_config_decode_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  pclk;
	logic                  presetn;
	logic                  osc_ready;
	logic                  pready;
	logic                  pslverr;
	logic                  pbe;
	logic [1:0]            pbd;
	logic [15:0]           ref_khz;
	logic [23:0]           khz;
	logic [31:0]           prdata;
	logic [31:0]           w1;
	logic [31:0]           w2;
	opd_pkg::opd_apb_req_s req;
	opd_pkg::opd_setup_s   setup;
	opd_pkg::opd_src_e     src;
	int                    err_count;
	int                    n_checks;
	int                    mul_t [8] = '{15, 16, 17, 18, 19, 20, 21, 24};

	opd_config_decode i_opd_config_decode (.pclk(pclk), .presetn(presetn), .apb_req(req),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_config_word_one(w1),
		.pll_config_word_two(w2), .osc_ready(osc_ready), .pll_ref_khz(ref_khz),
		.clock_setup(setup), .active_source(src), .periph_bus_enable(pbe),
		.periph_bus_divisor(pbd), .clock_output(), .clock_output_oe(), .pll_out_khz(khz));

	// Free-running bench clock, 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error taken at the pready edge only
	task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic ee);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!wr) chk(prdata, exp);
		chk(32'(pslverr), 32'(ee));
		req <= '0;
	endtask

	task t_cfg(input logic [2:0] i);
		int sh;
		sh = (i == 3'h7) ? 8 : int'(i);
		@(posedge pclk);
		presetn   <= 1'b0;
		osc_ready <= 1'b0;
		// All four primary modes, never off while plain primary is picked
		w1 <= {16'hFFFF, i[1:0], i[1:0], 1'b1, i[2], i[0], ~i[1], i[2], 1'b1, i[1], 2'b11,
			i};
		w2 <= {13'h1FFF, i, i[0], 4'hF, i, 1'b1, i, 1'b1, 3'h0};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(pbd), 32'(i[1:0]));
		if (i == 3'h4) begin
			chk(32'(src), 32'h0000_0000);
			osc_ready <= 1'b1;
			repeat (3) @(posedge pclk);
		end
		chk(32'(src), 32'(i));
		xfer(1'b0, 8'h00, 32'h0, w1, 1'b0);
		xfer(1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 8'h04, 32'h0, w2, 1'b0);
		xfer(1'b0, 8'h10, 32'h0, 32'((1000 * mul_t[i]) >> sh), 1'b0);
		xfer(1'b0, 8'h08, 32'h0, {25'h000_0000, i, 4'hB}, 1'b0);
		$display("config %0d done", i);
	endtask

	// Override the bus divisor, then let the spacing checker watch it
	task t_ctl();
		// Word one asks for divide by 8, so divide by 1 is a visible change
		xfer(1'b1, 8'h0C, 32'h0000_0004, 32'h0, 1'b0);
		xfer(1'b0, 8'h0C, 32'h0, 32'h0000_0004, 1'b0);
		chk(32'(pbd), 32'h0000_0000);
		repeat (24) @(posedge pclk);
		xfer(1'b1, 8'h0C, 32'h0000_0007, 32'h0, 1'b0);
		xfer(1'b0, 8'h0C, 32'h0, 32'h0000_0007, 1'b0);
		chk(32'(pbd), 32'h0000_0003);
		repeat (24) @(posedge pclk);
		xfer(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
		$display("control done");
	endtask

	task finish_test();
		$display("checks=%0d mismatches=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Hang guard, well past the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		finish_test();
	end

	initial begin
		presetn   = 1'b0;
		req       = '0;
		w1        = '1;
		w2        = '1;
		osc_ready = 1'b0;
		ref_khz   = 16'h03E8;
		repeat (16) @(posedge pclk);
		for (int i = 0; i < 8; i++) t_cfg(3'(i));
		t_ctl();
		finish_test();
	end
endmodule
